// ### ais_i2c_target.sv
// Purpose: Two-wire target port; decodes address, acks, moves register bytes
// Assumes: SCL and SDA are pins, synchronised here; SCL at most 400 kHz
// Notes:   Byte framing counts eight SCL rises before the ninth-bit decision
// Operation
// [RULE_01] Port acts as two-wire target only while serial select input is high.
// [RULE_02] Standard and fast SCL rates accepted; controller keeps SCL at most fast rate.
// [RULE_03] Address select high: answer 7-bit address 0x1D (0x3A write, 0x3B read).
// [RULE_04] Address select low: answer 7-bit address 0x53 (0xA6 write, 0xA7 read).
// [RULE_05] Write: address, index, data bytes, stop; every byte acknowledged by target.
// [RULE_06] Read: index write, restart, read address; controller nacks last byte.
// [RULE_07] Register index advances by one after each data byte.
`timescale 1ns/1ps
`include "ais_defs.svh"
module ais_i2c_target (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // Pins
    input  wire logic              serial_sel_pin,
    input  wire logic              address_select_pin,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    // Register bank side
    output ais_pkg::ais_reg_req_t  reg_req,
    input  wire logic [7:0]        reg_rdata
);
    import ais_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_sync_ff, sda_sync_ff, sel_sync_ff, alt_sync_ff;
    logic       scl_d_ff, sda_d_ff;

    // Two flops per pin, plus a delay flop on SCL and SDA for edge detect; stage 1 is never read elsewhere
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            sel_sync_ff <= 2'h0;
            alt_sync_ff <= 2'h0;
            scl_d_ff    <= 1'h1;
            sda_d_ff    <= 1'h1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            sel_sync_ff <= {sel_sync_ff[0], serial_sel_pin};
            alt_sync_ff <= {alt_sync_ff[0], address_select_pin};
            scl_d_ff    <= scl_sync_ff[1];
            sda_d_ff    <= sda_sync_ff[1];
        end
    end

    // Bus events
    wire scl_s   = scl_sync_ff[1];
    wire sda_s   = sda_sync_ff[1];
    wire port_on = sel_sync_ff[1];                          // RULE_01
    // Edge detect on the system clock serves both bus rates alike
    wire scl_re  = scl_s & ~scl_d_ff;                       // RULE_02
    wire scl_fe  = ~scl_s & scl_d_ff;
    wire start_c = port_on & scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_c  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // Own address from the strap
    wire [6:0] own_addr = alt_sync_ff[1] ? `AIS_ADDR_ALT_HI    // RULE_03
                                         : `AIS_ADDR_ALT_LO;   // RULE_04

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    ais_state_t   state_ff, nxt_state;
    logic [7:0]   shift_ff, nxt_shift;
    logic [2:0]   bit_ff, nxt_bit;
    logic [7:0]   idx_ff, nxt_idx;
    logic         idx_seen_ff, nxt_idx_seen;
    logic         sda_lo_ff, nxt_sda_lo;
    // Set on the eighth SCL rise of a received byte; the count wraps to zero there,
    // so the bit counter alone cannot tell a full byte from an empty one
    logic         full_ff, nxt_full;
    ais_reg_req_t req_ff, nxt_req;

    wire [7:0] idx_inc   = idx_ff + 8'h01;
    wire       addr_hit  = (shift_ff[7:1] == own_addr);
    wire       byte_done = (bit_ff == `AIS_BIT_LAST);

    // Next-state logic; bits sampled on SCL rise, SDA changed on SCL fall
    always_comb begin
        nxt_state    = state_ff;
        nxt_shift    = shift_ff;
        nxt_bit      = bit_ff;
        nxt_idx      = idx_ff;
        nxt_idx_seen = idx_seen_ff;
        nxt_sda_lo   = sda_lo_ff;
        nxt_full     = full_ff;
        nxt_req      = '0;
        nxt_req.idx  = idx_ff;
        nxt_req.wdata = shift_ff;
        if (!port_on || stop_c) begin
            nxt_state  = AIS_IDLE;                           // RULE_01
            nxt_sda_lo = 1'h0;
            nxt_full   = 1'h0;
        end else if (start_c) begin
            nxt_state  = AIS_ADDR;                           // RULE_06
            nxt_bit    = 3'h0;
            nxt_sda_lo = 1'h0;
            nxt_full   = 1'h0;
        end else begin
            case (state_ff)
                AIS_ADDR: begin
                    if (scl_re) begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_bit   = bit_ff + 3'h1;
                        nxt_full  = byte_done;
                    end else if (scl_fe && full_ff && addr_hit) begin
                        nxt_sda_lo = 1'h1;                   // RULE_05
                        nxt_full   = 1'h0;
                        nxt_state  = AIS_ADDR_ACK;
                    end else if (scl_fe && full_ff) begin
                        nxt_full  = 1'h0;
                        nxt_state = AIS_IDLE;
                    end
                end
                AIS_ADDR_ACK: begin
                    if (scl_fe && shift_ff[0]) begin
                        nxt_state   = AIS_RD_BYTE;           // RULE_06
                        nxt_shift   = reg_rdata;
                        nxt_sda_lo  = ~reg_rdata[7];
                        nxt_bit     = 3'h0;
                        nxt_req.rd_stb = 1'h1;
                    end else if (scl_fe) begin
                        nxt_state    = AIS_WR_BYTE;
                        nxt_sda_lo   = 1'h0;
                        nxt_bit      = 3'h0;
                        nxt_idx_seen = 1'h0;
                    end
                end
                AIS_WR_BYTE: begin
                    if (scl_re) begin
                        nxt_shift = {shift_ff[6:0], sda_s};
                        nxt_bit   = bit_ff + 3'h1;
                        nxt_full  = byte_done;
                    end else if (scl_fe && full_ff) begin
                        nxt_sda_lo = 1'h1;                   // RULE_05
                        nxt_full   = 1'h0;
                        nxt_state  = AIS_WR_ACK;
                        if (!idx_seen_ff) begin
                            nxt_idx      = shift_ff;
                            nxt_idx_seen = 1'h1;
                        end else begin
                            nxt_req.wr_stb = 1'h1;
                            nxt_idx        = idx_inc;        // RULE_07
                        end
                    end
                end
                AIS_WR_ACK: begin
                    if (scl_fe) begin
                        nxt_sda_lo = 1'h0;
                        nxt_bit    = 3'h0;
                        nxt_state  = AIS_WR_BYTE;
                    end
                end
                AIS_RD_BYTE: begin
                    if (scl_fe && byte_done) begin
                        nxt_sda_lo = 1'h0;                   // Release for controller ack
                        nxt_idx    = idx_inc;                // RULE_07
                        nxt_state  = AIS_RD_ACK;
                    end else if (scl_fe) begin
                        nxt_shift  = {shift_ff[6:0], 1'h0};
                        nxt_sda_lo = ~shift_ff[6];
                        nxt_bit    = bit_ff + 3'h1;
                    end
                end
                AIS_RD_ACK: begin
                    if (scl_re && sda_s) begin
                        nxt_state = AIS_IDLE;                // RULE_06
                    end else if (scl_re) begin
                        nxt_req.idx    = idx_ff;
                        nxt_req.rd_stb = 1'h1;
                    end else if (scl_fe) begin
                        nxt_state  = AIS_RD_BYTE;
                        nxt_shift  = reg_rdata;
                        nxt_sda_lo = ~reg_rdata[7];
                        nxt_bit    = 3'h0;
                    end
                end
                default: begin
                    nxt_state = AIS_IDLE;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff    <= AIS_IDLE;
            shift_ff    <= 8'h00;
            bit_ff      <= 3'h0;
            idx_ff      <= `AIS_REG_IDX_RST;
            idx_seen_ff <= 1'h0;
            sda_lo_ff   <= 1'h0;
            full_ff     <= 1'h0;
            req_ff      <= '0;
        end else begin
            state_ff    <= nxt_state;
            shift_ff    <= nxt_shift;
            bit_ff      <= nxt_bit;
            idx_ff      <= nxt_idx;
            idx_seen_ff <= nxt_idx_seen;
            sda_lo_ff   <= nxt_sda_lo;
            full_ff     <= nxt_full;
            req_ff      <= nxt_req;
        end
    end

    // Open-drain SDA: drive low only
    assign sda_out = 1'h0;
    assign sda_oe  = sda_lo_ff;
    assign reg_req = req_ff;
endmodule : ais_i2c_target

// ### ais_defs.svh
// Purpose: Constants for the accelerometer two-wire target port
// Assumes: 10 MHz system clock
// Notes:   Offsets and counts as macros; types live in ais_pkg
`ifndef AIS_DEFS_SVH
`define AIS_DEFS_SVH
`define AIS_ADDR_ALT_HI   7'h1d
`define AIS_ADDR_ALT_LO   7'h53
`define AIS_CLK_HZ        10000000
`define AIS_SCL_FAST_HZ   400000
`define AIS_SCL_STD_HZ    100000
// Least SCL high period at fast mode, in cycles (rounded down, no lower bound)
`define AIS_SCL_HI_CYC    ((`AIS_CLK_HZ / `AIS_SCL_FAST_HZ) / 4)
`define AIS_REG_IDX_RST   8'h00
`define AIS_BIT_LAST      3'h7
`endif

// ### ais_pkg.sv
// Purpose: Types for the accelerometer two-wire target port
// Assumes: Nothing beyond the constants header
// Notes:   Register-side request carrier and serial engine states
package ais_pkg;
    // Register access request toward the register bank
    typedef struct packed {
        logic       wr_stb;
        logic       rd_stb;
        logic [7:0] idx;
        logic [7:0] wdata;
    } ais_reg_req_t;

    // Serial engine states
    typedef enum logic [2:0] {
        AIS_IDLE,
        AIS_ADDR,
        AIS_ADDR_ACK,
        AIS_WR_BYTE,
        AIS_WR_ACK,
        AIS_RD_BYTE,
        AIS_RD_ACK
    } ais_state_t;
endpackage : ais_pkg

// ### ais_i2c_target_properties.sv
// Purpose: Port checks for the two-wire target
// Assumes: Raw pin levels, reset active high
// Notes:   Bound to every target instance
`timescale 1ns/1ps
module ais_chk (
    // Clock and pins
    input wire logic                  clk_sys,
    input wire logic                  sys_rst,
    input wire logic                  serial_sel_pin,
    input wire logic                  scl_in,
    input wire logic                  sda_in,
    input wire logic                  sda_oe,
    // Register side
    input wire ais_pkg::ais_reg_req_t reg_req
);
    import ais_pkg::*;
    // ----
    // Frame tracking for index steps
    // ----
    logic       sda_d_ff;
    logic       seen_ff;
    logic [7:0] last_ff;
    wire        edge_seen = scl_in && (sda_d_ff != sda_in);
    wire        stb = reg_req.wr_stb | reg_req.rd_stb;
    // Last strobed index, forgotten at START or STOP
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sda_d_ff <= 1'b1;
            seen_ff <= 1'b0;
            last_ff <= 8'h00;
        end else begin
            sda_d_ff <= sda_in;
            seen_ff <= !edge_seen && (seen_ff || stb);
            last_ff <= stb ? reg_req.idx : last_ff;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_sel_quiet: assert property (!serial_sel_pin [*4] |-> !sda_oe && !stb)
        else $error("drive while deselected");
    chk_oe_hold: assert property ($rose(sda_oe) |=> sda_oe [*6])
        else $error("pull too short");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data moved while clock high");
    chk_wr_ack: assert property (reg_req.wr_stb |-> ##[0:2] sda_oe)
        else $error("written byte not acked");
    chk_wr_pulse: assert property (reg_req.wr_stb |=> !reg_req.wr_stb)
        else $error("write strobe too long");
    chk_rd_pulse: assert property (reg_req.rd_stb |=> !reg_req.rd_stb)
        else $error("read strobe too long");
    chk_no_both: assert property (!(reg_req.wr_stb && reg_req.rd_stb))
        else $error("read and write together");
    chk_idx_step: assert property (stb && seen_ff |-> reg_req.idx == last_ff + 8'h01)
        else $error("index did not step by one");
    cover property (reg_req.wr_stb && seen_ff);
    cover property (reg_req.rd_stb && seen_ff);
    cover property ($rose(sda_oe));
endmodule : ais_chk
bind ais_i2c_target ais_chk ais_chk_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .serial_sel_pin(serial_sel_pin), .scl_in(scl_in), .sda_in(sda_in),
    .sda_oe(sda_oe), .reg_req(reg_req));

// ### ais_host_model.sv
// Purpose: Bus controller driving clock and framing
// Assumes: Lines pulled up when released
// Notes:   half sets the SCL rate in clocks
`timescale 1ns/1ps
module ais_host_model (
    // Clock and bus lines
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic     scl_ff,
    output logic     sda_rel_ff
);
    int half = 13;  // 26 clocks a bit, just under the fast rate
    initial begin
        scl_ff = 1'b1;
        sda_rel_ff = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : w
    // One bit; data set mid-low, line sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        w(half / 2);
        sda_rel_ff <= b;
        w(half - half / 2);
        scl_ff <= 1'b1;
        w(half / 2);
        s = sda_line;
        w(half - half / 2);
        scl_ff <= 1'b0;
    endtask : bit_io
    // START or repeated START
    task automatic start_c();
        w(half / 2);
        sda_rel_ff <= 1'b1;
        w(half / 2);
        scl_ff <= 1'b1;
        w(half);
        sda_rel_ff <= 1'b0;
        w(half);
        scl_ff <= 1'b0;
    endtask : start_c
    task automatic stop_c();
        w(half / 2);
        sda_rel_ff <= 1'b0;
        w(half / 2);
        scl_ff <= 1'b1;
        w(half);
        sda_rel_ff <= 1'b1;
        w(half * 2);
    endtask : stop_c
    // Byte MSB first, then the handshake bit; ninth 1 releases or NACKs
    task automatic xfer(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ninth, ack);
    endtask : xfer
endmodule : ais_host_model

// ### testbench.sv
// Purpose: Self-checking bench for the two-wire target
// Assumes: Bank data is index xor 5a
// Notes:   Random indices, data and addresses
`timescale 1ns/1ps
`include "ais_defs.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
    import ais_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic serial_sel_pin = 1'b1;
    logic address_select_pin = 1'b1;
    logic sda_oe, sda_out, scl_ff, sda_rel_ff, ack;
    logic [7:0] rx, base;
    ais_reg_req_t reg_req;
    int err_count = 0;
    int n_compared = 0;
    logic [15:0] wq[$];
    wire sda_line = sda_rel_ff & ~(sda_oe & ~sda_out);
    initial forever #50 clk_sys = ~clk_sys;
    ais_i2c_target ais_i2c_target_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .serial_sel_pin(serial_sel_pin), .address_select_pin(address_select_pin),
        .scl_in(scl_ff), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .reg_req(reg_req), .reg_rdata(reg_req.idx ^ 8'h5a));
    ais_host_model hst (.clk_sys(clk_sys), .sda_line(sda_line), .scl_ff(scl_ff),
        .sda_rel_ff(sda_rel_ff));
    // Capture every write strobe
    always @(posedge clk_sys) if (reg_req.wr_stb) wq.push_back({reg_req.idx, reg_req.wdata});
    task automatic test_done();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    // Write n bytes at a random index; if addressed, read three from that index
    task automatic wr_rd(input logic [6:0] a, input int n);
        logic [7:0] d[$];
        logic [6:0] own;
        logic hit;
        own = address_select_pin ? `AIS_ADDR_ALT_HI : `AIS_ADDR_ALT_LO;
        hit = (a == own) && serial_sel_pin;
        base = 8'($urandom);
        wq.delete();
        hst.start_c();
        hst.xfer({a, 1'b0}, 1'b1, rx, ack);
        `CHK("addr ack", !hit, ack)
        for (int k = 0; hit && k <= n; k++) begin
            d.push_back(k == 0 ? base : 8'($urandom));
            hst.xfer(d[k], 1'b1, rx, ack);
            `CHK("byte ack", 1'b0, ack)
        end
        hst.stop_c();
        `CHK("wr count", hit ? n : 0, wq.size())
        for (int k = 0; hit && k < n; k++) `CHK("wr strobe", {base + 8'(k), d[k + 1]}, wq[k])
        if (hit) begin
            hst.start_c();
            hst.xfer({own, 1'b0}, 1'b1, rx, ack);
            hst.xfer(base, 1'b1, rx, ack);
            hst.start_c();
            hst.xfer({own, 1'b1}, 1'b1, rx, ack);
            `CHK("rd addr ack", 1'b0, ack)
            for (int k = 0; k < 3; k++) begin
                hst.xfer(8'hff, k == 2, rx, ack);
                `CHK("rd data", (base + 8'(k)) ^ 8'h5a, rx)
            end
            hst.stop_c();
        end
    endtask : wr_rd
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'hb4ce2706));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int s = 1; s >= 0; s--) begin
            address_select_pin <= s[0];
            repeat (4) @(posedge clk_sys);
            wr_rd(`AIS_ADDR_ALT_HI, 3);
            wr_rd(`AIS_ADDR_ALT_LO, 1);
            wr_rd(7'($urandom), 2);
        end
        hst.half = 50;
        wr_rd(`AIS_ADDR_ALT_LO, 2);
        serial_sel_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        wr_rd(`AIS_ADDR_ALT_LO, 1);
        test_done();
    end
endmodule : testbench
